/* File: design/sbo_defines.svh */
// Constants of the skip, branch, OR and increment execution block.
// Assumes inclusion by bare name from the package and design modules.
`ifndef SBO_DEFINES_SVH
`define SBO_DEFINES_SVH
// ==========================================================
// Instruction word fields (14-bit words)
`define SBO_OPC_WIDTH 14
`define SBO_FADDR_MSB 6
`define SBO_DEST_BIT 7
`define SBO_LIT_MSB 7
`define SBO_BRANCH_MSB 10
// ==========================================================
// Opcode patterns
`define SBO_OP6_DECSKIP 6'h0b
`define SBO_OP6_INCSKIP 6'h0f
`define SBO_OP6_INCFILE 6'h0a
`define SBO_OP6_ORFILE 6'h04
`define SBO_OP4_ORLIT 4'he
`define SBO_OP3_BRANCH 3'h5
// ==========================================================
// Widths and reset values
`define SBO_PC_WIDTH 13
`define SBO_PC_RESET 13'h0000
`define SBO_W_RESET 8'h00
`define SBO_PCLH_LO 3
`define SBO_PCLH_HI 4
`endif

/* File: design/sbo_pkg.sv */
// Types shared by the skip, branch, OR and increment execution block.
// Assumes the defines header is on the include path.
`include "sbo_defines.svh"
package sbo_pkg;
    // Decoded operation
    typedef enum logic [2:0]
    {
        SBO_NONE,
        SBO_DEC_SKIP,
        SBO_INC_SKIP,
        SBO_BRANCH,
        SBO_OR_LIT,
        SBO_INC_FILE,
        SBO_OR_FILE
    } sbo_op_type;
    // Execution sequencer state
    typedef enum logic [1:0]
    {
        SBO_RUN,
        SBO_FLUSH
    } sbo_state_type;
endpackage : sbo_pkg

/* File: design/sbo_decode.sv */
// Decoder: instruction word to operation class.
// Assumes a 14-bit instruction word valid in the same cycle.
`include "sbo_defines.svh"
module sbo_decode
(
    // Instruction
    input wire logic [13:0] instr,
    // Decoded class
    output sbo_pkg::sbo_op_type op
);
    // ==========================================================
    // Opcode match
    always_comb
    begin
        op = sbo_pkg::SBO_NONE;
        if (instr[13:11] == `SBO_OP3_BRANCH)
            op = sbo_pkg::SBO_BRANCH;
        else if (instr[13:8] == `SBO_OP6_DECSKIP)
            op = sbo_pkg::SBO_DEC_SKIP;
        else if (instr[13:8] == `SBO_OP6_INCSKIP)
            op = sbo_pkg::SBO_INC_SKIP;
        else if (instr[13:8] == `SBO_OP6_INCFILE)
            op = sbo_pkg::SBO_INC_FILE;
        else if (instr[13:8] == `SBO_OP6_ORFILE)
            op = sbo_pkg::SBO_OR_FILE;
        else if (instr[13:10] == `SBO_OP4_ORLIT)
            op = sbo_pkg::SBO_OR_LIT; // Low two opcode bits are don't care
    end
endmodule : sbo_decode

/* File: design/sbo_exec.sv */
// Execution unit for decrement/increment-and-skip, branch, OR and increment.
// Assumes the core presents one instruction per cycle with file data read
// combinationally from the current word's instr[6:0]; file writes happen outside on file_we.
`include "sbo_defines.svh"
module sbo_exec
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Instruction stream
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    // File register side
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] pc_latch_high,
    output logic [6:0] file_addr_r,
    output logic [7:0] file_wdata_r,
    output logic file_we_r,
    // Core state
    output logic [7:0] work_r,
    output logic [12:0] pc_r,
    output logic zero_flag_r,
    output logic zero_we_r,
    output logic instr_done_r
);
    // ==========================================================
    // Decode
    sbo_pkg::sbo_op_type op;
    sbo_pkg::sbo_state_type state_r;
    sbo_pkg::sbo_state_type state_nxt;
    logic [7:0] result;
    logic to_file;
    logic [6:0] file_addr_nxt;
    logic [7:0] file_wdata_nxt;
    logic file_we_nxt;
    logic [7:0] work_nxt;
    logic [12:0] pc_nxt;
    logic zero_flag_nxt;
    logic zero_we_nxt;
    logic instr_done_nxt;

    sbo_decode u_decode
    (
        .instr(instr),
        .op(op)
    );

    // Result zero test shared by skips and flag updates
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == 8'h00);
    endfunction : is_zero

    // The two skip forms share the squash decision
    function automatic logic is_skip(input sbo_pkg::sbo_op_type o);
        is_skip = (o == sbo_pkg::SBO_DEC_SKIP) || (o == sbo_pkg::SBO_INC_SKIP);
    endfunction : is_skip

    // ==========================================================
    // Result datapath
    // Only a valid word in the run state executes; the flush slot is a NOP
    logic exec_now;
    always_comb
    begin
        exec_now = instr_valid && (state_r == sbo_pkg::SBO_RUN);
        to_file = instr[`SBO_DEST_BIT];
        case (op)
            sbo_pkg::SBO_DEC_SKIP:
                result = file_rdata - 8'h01;
            sbo_pkg::SBO_INC_SKIP, sbo_pkg::SBO_INC_FILE:
                result = file_rdata + 8'h01;
            sbo_pkg::SBO_OR_FILE:
                result = work_r | file_rdata;
            sbo_pkg::SBO_OR_LIT:
            begin
                result = work_r | instr[`SBO_LIT_MSB:0];
                to_file = 1'b0; // Literal form has no file operand
            end
            default:
                result = 8'h00;
        endcase
    end

    // ==========================================================
    // Sequencer: program counter, flush slot and completion pulse
    always_comb
    begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        instr_done_nxt = 1'b0;
        case (state_r)
            sbo_pkg::SBO_RUN:
            begin
                if (instr_valid)
                begin
                    pc_nxt = pc_r + 13'h0001;
                    instr_done_nxt = 1'b1;
                    if (op == sbo_pkg::SBO_BRANCH)
                    begin
                        // Unconditional; second cycle flushes the prefetch
                        pc_nxt = {pc_latch_high[`SBO_PCLH_HI:`SBO_PCLH_LO],
                                  instr[`SBO_BRANCH_MSB:0]};
                        state_nxt = sbo_pkg::SBO_FLUSH;
                        instr_done_nxt = 1'b0;
                    end
                    else if (is_skip(op) && is_zero(result))
                    begin
                        // Zero result squashes the next word
                        state_nxt = sbo_pkg::SBO_FLUSH;
                        instr_done_nxt = 1'b0;
                    end
                end
            end
            sbo_pkg::SBO_FLUSH:
            begin
                // Executes a NOP in place of the discarded word
                if (instr_valid)
                begin
                    state_nxt = sbo_pkg::SBO_RUN;
                    pc_nxt = pc_r + 13'h0001;
                    instr_done_nxt = 1'b1;
                end
            end
            default:
                state_nxt = sbo_pkg::SBO_RUN;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= sbo_pkg::SBO_RUN;
            pc_r <= `SBO_PC_RESET;
            instr_done_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            instr_done_r <= instr_done_nxt;
        end
    end

    // ==========================================================
    // Result routing to W or the file register
    // A skip still writes its result; only the following word is squashed
    always_comb
    begin
        file_addr_nxt = file_addr_r;
        file_wdata_nxt = file_wdata_r;
        file_we_nxt = 1'b0;
        work_nxt = work_r;
        if (exec_now)
        begin
            file_addr_nxt = instr[`SBO_FADDR_MSB:0];
            case (op)
                sbo_pkg::SBO_DEC_SKIP, sbo_pkg::SBO_INC_SKIP, sbo_pkg::SBO_INC_FILE,
                sbo_pkg::SBO_OR_FILE, sbo_pkg::SBO_OR_LIT:
                begin
                    if (to_file)
                    begin
                        file_we_nxt = 1'b1;
                        file_wdata_nxt = result;
                    end
                    else
                    begin
                        work_nxt = result;
                    end
                end
                default:
                    work_nxt = work_r;
            endcase
        end
    end

    // Routing registers
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            file_addr_r <= 7'h00;
            file_wdata_r <= 8'h00;
            file_we_r <= 1'b0;
            work_r <= `SBO_W_RESET;
        end
        else
        begin
            file_addr_r <= file_addr_nxt;
            file_wdata_r <= file_wdata_nxt;
            file_we_r <= file_we_nxt;
            work_r <= work_nxt;
        end
    end

    // ==========================================================
    // Zero flag; the skip forms and the branch leave it alone
    always_comb
    begin
        zero_flag_nxt = zero_flag_r;
        zero_we_nxt = 1'b0;
        if (exec_now)
        begin
            case (op)
                sbo_pkg::SBO_INC_FILE, sbo_pkg::SBO_OR_FILE, sbo_pkg::SBO_OR_LIT:
                begin
                    zero_we_nxt = 1'b1;
                    zero_flag_nxt = is_zero(result);
                end
                default:
                    zero_we_nxt = 1'b0;
            endcase
        end
    end

    // Flag registers
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            zero_flag_r <= 1'b0;
            zero_we_r <= 1'b0;
        end
        else
        begin
            zero_flag_r <= zero_flag_nxt;
            zero_we_r <= zero_we_nxt;
        end
    end
endmodule : sbo_exec

/* File: testbench/sbo_exec_asserts.sv */
// Checker for the skip, branch, OR and increment execution unit.
// Assumes it is bound to sbo_exec and sees only that module's ports.
`include "sbo_defines.svh"
module sbo_exec_asserts
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Stimulus side
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] pc_latch_high,
    // Results
    input wire logic [6:0] file_addr_r,
    input wire logic [7:0] file_wdata_r,
    input wire logic file_we_r,
    input wire logic [7:0] work_r,
    input wire logic [12:0] pc_r,
    input wire logic zero_flag_r,
    input wire logic zero_we_r,
    input wire logic instr_done_r
);
    // ======================================================
    // Decode seen from outside; a word after a taken skip or branch is dropped
    logic fl_r;
    wire ex = instr_valid && !fl_r;
    wire dsk = ex && instr[13:8] == `SBO_OP6_DECSKIP;
    wire isk = ex && instr[13:8] == `SBO_OP6_INCSKIP;
    wire br = ex && instr[13:11] == `SBO_OP3_BRANCH;
    wire orl = ex && instr[13:10] == `SBO_OP4_ORLIT;
    wire inf = ex && instr[13:8] == `SBO_OP6_INCFILE;
    wire orf = ex && instr[13:8] == `SBO_OP6_ORFILE;
    wire sk = dsk && file_rdata == 8'h01 || isk && file_rdata == 8'hff;
    wire [12:0] tgt = {pc_latch_high[4:3], instr[10:0]};
    wire [7:0] orl_v = work_r | instr[7:0];
    wire [7:0] orf_v = work_r | file_rdata;
    // Flush tracker; only a valid word moves it, so idle cycles keep it
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            fl_r <= 1'b0;
        else if (instr_valid)
            fl_r <= br || sk;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    property p_dec_w; dsk && !instr[7] |=> work_r == $past(file_rdata) - 8'h01; endproperty
    property p_dec_f; dsk && instr[7] |=> file_we_r && file_addr_r == $past(instr[6:0]); endproperty
    property p_inc_w; isk && !instr[7] |=> work_r == $past(file_rdata) + 8'h01; endproperty
    property p_skip; sk |=> !instr_done_r && file_we_r == $past(instr[7]); endproperty
    property p_drop;
        instr_valid && fl_r |=> instr_done_r && !file_we_r && !zero_we_r && $stable(work_r);
    endproperty
    property p_noflag; dsk || isk |=> !zero_we_r && $stable(zero_flag_r); endproperty
    property p_br; br |=> pc_r == $past(tgt) && !instr_done_r; endproperty
    property p_orl; orl |=> work_r == $past(orl_v) && zero_we_r && zero_flag_r == !work_r; endproperty
    property p_inf; inf && instr[7] |=> file_wdata_r == $past(file_rdata) + 8'h01; endproperty
    property p_orf; orf |=> zero_we_r && zero_flag_r == ($past(orf_v) == 8'h00); endproperty
    a_dec_w: assert property (p_dec_w) else $error("decrement result to W wrong");
    a_dec_f: assert property (p_dec_f) else $error("decrement file write wrong");
    a_inc_w: assert property (p_inc_w) else $error("increment result to W wrong");
    a_skip: assert property (p_skip) else $error("zero skip did not stall");
    a_drop: assert property (p_drop) else $error("dropped word had an effect");
    a_noflag: assert property (p_noflag) else $error("skip touched zero flag");
    a_br: assert property (p_br) else $error("branch target wrong");
    a_orl: assert property (p_orl) else $error("literal OR wrong");
    a_inf: assert property (p_inf) else $error("increment file data wrong");
    a_orf: assert property (p_orf) else $error("file OR zero flag wrong");
    c_skip: cover property (sk ##1 instr_valid);
    c_br: cover property (br);
    c_orl: cover property (orl && orl_v == 8'h00);
endmodule : sbo_exec_asserts
bind sbo_exec sbo_exec_asserts u_chk (.core_clk(core_clk), .reset_n(reset_n),
    .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata),
    .pc_latch_high(pc_latch_high), .file_addr_r(file_addr_r), .file_wdata_r(file_wdata_r),
    .file_we_r(file_we_r), .work_r(work_r), .pc_r(pc_r), .zero_flag_r(zero_flag_r),
    .zero_we_r(zero_we_r), .instr_done_r(instr_done_r));

/* File: testbench/sbo_exec_test.sv */
// Self-checking bench for the execution unit.
// Assumes sbo_exec with its checker bound; one word per two cycles.
module sbo_exec_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================
    // Signals
    logic core_clk, reset_n, instr_valid, file_we_r, zero_flag_r, zero_we_r, instr_done_r;
    logic [13:0] instr;
    logic [7:0] file_rdata, pc_latch_high, file_wdata_r, work_r;
    logic [6:0] file_addr_r;
    logic [12:0] pc_r;
    int n_mismatch = 0;
    int samples_checked = 0;
    sbo_exec u_dut (.core_clk(core_clk), .reset_n(reset_n), .instr_valid(instr_valid),
        .instr(instr), .file_rdata(file_rdata), .pc_latch_high(pc_latch_high),
        .file_addr_r(file_addr_r), .file_wdata_r(file_wdata_r), .file_we_r(file_we_r),
        .work_r(work_r), .pc_r(pc_r), .zero_flag_r(zero_flag_r), .zero_we_r(zero_we_r),
        .instr_done_r(instr_done_r));
    // 250 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic chk(input string n, input logic [12:0] s, input logic [12:0] e);
        samples_checked++;
        if (s !== e)
        begin
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
            n_mismatch++;
        end
    endtask : chk
    // One word; the gap cycle after it keeps valid from being driven twice at one edge
    task automatic go(input logic [13:0] w, input logic [7:0] fd);
        @(posedge core_clk);
        instr <= w;
        file_rdata <= fd;
        instr_valid <= 1'b1;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
    endtask : go
    task automatic t_dec;
        go(14'h0b10, 8'h05);
        chk("work", work_r, 8'h04);
        chk("we", file_we_r, 1'b0);
        go(14'h0bff, 8'h01);
        chk("wdata", file_wdata_r, 8'h00);
        chk("addr", file_addr_r, 7'h7f);
        chk("done", instr_done_r, 1'b0);
        chk("zwe", zero_we_r, 1'b0);
        go(14'h38ff, 8'h00);
        chk("work", work_r, 8'h04);
        chk("done", instr_done_r, 1'b1);
        $display("decrement skip test ended");
    endtask : t_dec
    task automatic t_inc;
        go(14'h0f10, 8'hff);
        chk("work", work_r, 8'h00);
        chk("done", instr_done_r, 1'b0);
        go(14'h0aa0, 8'h10);
        chk("we", file_we_r, 1'b0);
        go(14'h0fff, 8'hfe);
        chk("wdata", file_wdata_r, 8'hff);
        chk("done", instr_done_r, 1'b1);
        $display("increment skip test ended");
    endtask : t_inc
    task automatic t_br;
        @(posedge core_clk);
        pc_latch_high <= 8'hf7;
        go(14'h2d55, 8'h00);
        chk("pc", pc_r, 13'h1555);
        chk("done", instr_done_r, 1'b0);
        go(14'h3801, 8'h00);
        chk("pc", pc_r, 13'h1556);
        chk("work", work_r, 8'h00);
        $display("branch test ended");
    endtask : t_br
    task automatic t_or;
        go(14'h3800, 8'h00);
        chk("z", zero_flag_r, 1'b1);
        go(14'h38a5, 8'h00);
        chk("work", work_r, 8'ha5);
        chk("z", zero_flag_r, 1'b0);
        go(14'h04b3, 8'h5a);
        chk("wdata", file_wdata_r, 8'hff);
        chk("we", file_we_r, 1'b1);
        go(14'h0a20, 8'hff);
        chk("work", work_r, 8'h00);
        chk("z", zero_flag_r, 1'b1);
        go(14'h0000, 8'h00);
        chk("work", work_r, 8'h00);
        chk("zwe", zero_we_r, 1'b0);
        chk("pc", pc_r, 13'h155b);
        go(14'h0aa0, 8'h7f);
        chk("wdata", file_wdata_r, 8'h80);
        chk("we", file_we_r, 1'b1);
        chk("z", zero_flag_r, 1'b0);
        $display("OR and increment test ended");
    endtask : t_or
    task automatic close_out;
        $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out
    // Reset for 16 cycles, then the scenarios
    initial
    begin
        reset_n = 1'b0;
        instr_valid = 1'b0;
        instr = 14'h0000;
        file_rdata = 8'h00;
        pc_latch_high = 8'h00;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        t_dec();
        t_inc();
        t_br();
        t_or();
        close_out();
    end
endmodule : sbo_exec_test
